// ---- design/clk_backup_pkg.sv ----
package clk_backup_pkg;

  // core clock
  localparam int CLK_MHZ = 100;

  // register indices on the plain port bus
  localparam logic [7:0] ADDR_SLOW_SEL  = 8'h00;
  localparam logic [7:0] ADDR_BACKUP    = 8'h01;
  localparam logic [7:0] ADDR_FREQ_CTRL = 8'h02;
  localparam logic [7:0] ADDR_WAKE_TIME = 8'h03;
  localparam logic [7:0] ADDR_FAST_OUT  = 8'h04;

  // field positions
  localparam int BIT_BACKUP_SWITCH = 0;
  localparam int BIT_BACKUP_STATUS = 1;
  localparam int BIT_FAST_ENABLE   = 0;
  localparam int BIT_FAST_READY    = 1;
  localparam int BIT_WAKE_SELECT   = 0;
  localparam int BIT_DIV_OUT_EN    = 0;
  localparam int POS_DIV_SEL       = 1;

  // slow source select encodings
  localparam logic [1:0] SEL_RC      = 2'h0;
  localparam logic [1:0] SEL_CRYSTAL = 2'h1;
  localparam logic [1:0] SEL_EXT     = 2'h3;

  // reset values
  localparam logic [1:0] RST_SLOW_SEL = 2'h0;
  localparam logic [0:0] RST_FAST_EN  = 1'h0;
  localparam logic [0:0] RST_WAKE     = 1'h0;
  localparam logic [2:0] RST_FAST_OUT = 3'h0;

  // counts of source clock edges
  localparam logic [9:0]  RC_POWERUP_COUNT = 10'h200;
  localparam logic [9:0]  RC_WAKEUP_COUNT  = 10'h00a;
  localparam logic [13:0] XTAL_STAB_COUNT  = 14'h2000;

  // pll multipliers
  localparam logic [9:0] PLL_MULT_16M = 10'h1e8;
  localparam logic [9:0] PLL_MULT_24M = 10'h2dc;

  // times in their own units and the derived cycle counts
  localparam int XTAL_STOP_TIME_US   = 8000;
  localparam int PLL_EARLY_TIME_US   = 30;
  localparam int PLL_STABLE_TIME_NS  = 2500000;
  localparam int XTAL_START_TIME_MS  = 500;
  localparam logic [19:0] XTAL_STOP_CYC   = 20'(XTAL_STOP_TIME_US * CLK_MHZ);
  localparam logic [17:0] PLL_EARLY_CYC   = 18'(PLL_EARLY_TIME_US * CLK_MHZ);
  localparam logic [17:0] PLL_STABLE_CYC  = 18'((PLL_STABLE_TIME_NS / 1000) * CLK_MHZ);
  localparam logic [25:0] XTAL_START_CYC  = 26'(XTAL_START_TIME_MS * 1000 * CLK_MHZ);

  typedef enum logic [2:0] {
    BK_RC    = 3'b000,
    BK_START = 3'b001,
    BK_STAB  = 3'b010,
    BK_READY = 3'b011,
    BK_XTAL  = 3'b100,
    BK_FAIL  = 3'b101,
    BK_STOP  = 3'b110
  } backup_state_type;

endpackage

// ---- design/slow_clock_backup.sv ----
// How it works
// - power-up: RC source, 512 RC counts then run
// - deep-stop exit: 10 RC counts then run
// - system clock defaults to slow RC
// - two-bit select: RC, crystal, external
// - encodings 00, 01, 11; 00 returns to RC
// - crystal selected: crystal pin port config ignored
// - crystal monitored; stop switches to RC
// - crystal halted in STOP and deep-STOP
// - backup on select, stop exit, stop detect
// - failure flagged on stall, about 8 ms
// - RC supplied until crystal stabilizes
// - start time plus 8192 counts, then interrupt
// - software release routes crystal to slow clock
// - backup switch bit: set by hardware, write-one
// - only power-on reset clears select and crystal
// - deep-stop exit restarts crystal, backup mode
// - interrupt on failure and on recovery
// - external clock like crystal, input enable ignored
// - pll multiplies by 488 or 732
// - fast clock only after pll count completes
// - pll stopped in halt-fast, STOP, deep-STOP
// - early wake supplies fast clock after 30 us
// - wake select bit 0: stable or early start
// - divided fast clock on a port
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module slow_clock_backup
  import clk_backup_pkg::*;
#(
  parameter logic [25:0] XTAL_START_CYCLES = XTAL_START_CYC,
  parameter logic [19:0] XTAL_STOP_CYCLES  = XTAL_STOP_CYC,
  parameter logic [17:0] PLL_STABLE_CYCLES = PLL_STABLE_CYC
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_other_reset,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_rc_clk,
  input  wire logic       i_crystal_input_pin,
  input  wire logic       i_pll_clk,
  input  wire logic       i_pll_24mhz_option,
  input  wire logic       i_stop_mode,
  input  wire logic       i_deep_stop_mode,
  input  wire logic       i_halt_fast_mode,
  input  wire logic [1:0] i_crystal_pin_port_config,
  input  wire logic       i_crystal_in_port_input_en,
  output logic      [1:0] o_crystal_pin_port_config,
  output logic            o_crystal_in_port_input_en,
  output logic            o_crystal_osc_enable,
  output logic            o_slow_clock_out,
  output logic            o_slow_src_is_rc,
  output logic            o_cpu_run,
  output logic            o_clock_backup_irq,
  output logic            o_pll_enable,
  output logic      [9:0] o_pll_multiplier,
  output logic            o_fast_clock_out,
  output logic            o_divided_fast_clock_pin
);

  logic [2:0] rc_sync_q;
  logic [2:0] xt_sync_q;
  logic [2:0] pll_sync_q;
  logic [1:0] opt_sync_q;
  logic       rc_rise;
  logic       xt_rise;
  logic       pll_rise;
  logic       stop_any;
  logic       stop_any_q;
  logic       stop_exit;

  // sources cross from outside: two flops, then a third for edges
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rc_sync_q  <= 3'h0;
      xt_sync_q  <= 3'h0;
      pll_sync_q <= 3'h0;
      opt_sync_q <= 2'h0;
    end
    else
    begin
      rc_sync_q  <= {rc_sync_q[1:0], i_rc_clk};
      xt_sync_q  <= {xt_sync_q[1:0], i_crystal_input_pin};
      pll_sync_q <= {pll_sync_q[1:0], i_pll_clk};
      opt_sync_q <= {opt_sync_q[0], i_pll_24mhz_option};
    end
  end

  assign rc_rise  = rc_sync_q[1] & ~rc_sync_q[2];
  assign xt_rise  = xt_sync_q[1] & ~xt_sync_q[2];
  assign pll_rise = pll_sync_q[1] & ~pll_sync_q[2];
  assign stop_any = i_stop_mode | i_deep_stop_mode;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      stop_any_q <= 1'b0;
    else
      stop_any_q <= stop_any;
  end

  assign stop_exit = stop_any_q & ~stop_any;

  // register writes
  logic [1:0]       slow_sel_q;
  logic             fast_en_q;
  logic             wake_sel_q;
  logic [2:0]       fast_out_q;
  backup_state_type bk_q;
  logic             sel_xtal;
  logic             sel_write;
  logic             release_write;

  assign sel_write     = i_wr && (i_addr == ADDR_SLOW_SEL);
  assign release_write = i_wr && (i_addr == ADDR_BACKUP) && i_wdata[BIT_BACKUP_SWITCH];
  assign sel_xtal      = (slow_sel_q == SEL_CRYSTAL) || (slow_sel_q == SEL_EXT);

  // select survives every reset but power-on
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      slow_sel_q <= RST_SLOW_SEL;
    else if (sel_write)
    begin
      if (i_wdata[1:0] == SEL_CRYSTAL || i_wdata[1:0] == SEL_EXT || i_wdata[1:0] == SEL_RC)
        slow_sel_q <= i_wdata[1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      fast_en_q  <= RST_FAST_EN;
      wake_sel_q <= RST_WAKE;
      fast_out_q <= RST_FAST_OUT;
    end
    else if (i_other_reset)
    begin
      fast_en_q  <= RST_FAST_EN;
      wake_sel_q <= RST_WAKE;
      fast_out_q <= RST_FAST_OUT;
    end
    else if (i_wr)
    begin
      if (i_addr == ADDR_FREQ_CTRL)
        fast_en_q <= i_wdata[BIT_FAST_ENABLE];
      if (i_addr == ADDR_WAKE_TIME)
        wake_sel_q <= i_wdata[BIT_WAKE_SELECT];
      if (i_addr == ADDR_FAST_OUT)
        fast_out_q <= i_wdata[2:0];
    end
  end

  // crystal stall detector: core cycles since last crystal edge
  logic [19:0] stall_cnt_q;
  logic        stall;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      stall_cnt_q <= 20'h0;
    else if (xt_rise || !(bk_q == BK_XTAL || bk_q == BK_STAB))
      stall_cnt_q <= 20'h0;
    else if (!stall)
      stall_cnt_q <= stall_cnt_q + 20'h1;
  end

  assign stall = (stall_cnt_q == XTAL_STOP_CYCLES);

  // backup sequencer
  logic [25:0] start_cnt_q;
  logic [13:0] stab_cnt_q;
  logic        stab_done;
  logic        irq_q;
  logic        status_q;

  assign stab_done = xt_rise && (stab_cnt_q == XTAL_STAB_COUNT - 14'h1);

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      bk_q <= BK_RC;
    else if (sel_write && i_wdata[1:0] == SEL_RC)
      bk_q <= BK_RC;
    else if (sel_write && (i_wdata[1:0] == SEL_CRYSTAL || i_wdata[1:0] == SEL_EXT) && !sel_xtal)
      bk_q <= BK_START;
    else if (sel_xtal && stop_any)
      bk_q <= BK_STOP;
    else
    begin
      case (bk_q)
        BK_RC:
          bk_q <= BK_RC;
        BK_START:
          if (start_cnt_q == XTAL_START_CYCLES)
            bk_q <= BK_STAB;
        BK_STAB:
          if (stab_done)
            bk_q <= BK_READY;
        BK_READY:
          if (release_write)
            bk_q <= BK_XTAL;
        BK_XTAL:
          if (stall)
            bk_q <= BK_FAIL;
        BK_FAIL:
          if (stab_done)
            bk_q <= BK_READY;
        BK_STOP:
          if (stop_exit)
            bk_q <= BK_START;
        default:
          bk_q <= BK_RC;
      endcase
    end
  end

  // start time in core cycles, stabilization in crystal edges
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      start_cnt_q <= 26'h0;
    else if (bk_q == BK_START)
      start_cnt_q <= start_cnt_q + 26'h1;
    else
      start_cnt_q <= 26'h0;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      stab_cnt_q <= 14'h0;
    else if (!(bk_q == BK_STAB || bk_q == BK_FAIL) || stall)
      stab_cnt_q <= 14'h0;
    else if (stab_done)
      stab_cnt_q <= 14'h0;
    else if (xt_rise)
      stab_cnt_q <= stab_cnt_q + 14'h1;
  end

  // interrupt pulse on stabilization, recovery and failure
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_q <= 1'b0;
    else
      irq_q <= ((bk_q == BK_STAB || bk_q == BK_FAIL) && stab_done && !stop_any && !sel_write)
               || (bk_q == BK_XTAL && stall && !stop_any && !sel_write);
  end

  // status: 1 while crystal stopped, starting, or in stop mode
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      status_q <= 1'b0;
    else if (sel_write && (i_wdata[1:0] == SEL_CRYSTAL || i_wdata[1:0] == SEL_EXT) && !sel_xtal)
      status_q <= 1'b1;
    else if ((sel_xtal && stop_any) || (bk_q == BK_XTAL && stall))
      status_q <= 1'b1;
    else if (stab_done && (bk_q == BK_STAB || bk_q == BK_FAIL))
      status_q <= 1'b0;
    else if (sel_write && i_wdata[1:0] == SEL_RC)
      status_q <= 1'b0;
  end

  // slow clock: rc until released onto the crystal
  logic [9:0] warm_cnt_q;
  logic       run_q;
  logic       use_xtal;
  logic       slow_q;

  assign use_xtal = (bk_q == BK_XTAL);

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      warm_cnt_q <= RC_POWERUP_COUNT;
      run_q      <= 1'b0;
    end
    else if (stop_any)
    begin
      warm_cnt_q <= RC_WAKEUP_COUNT;
      run_q      <= 1'b0;
    end
    else if (!run_q && rc_rise)
    begin
      if (warm_cnt_q == 10'h1)
        run_q <= 1'b1;
      warm_cnt_q <= warm_cnt_q - 10'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      slow_q <= 1'b0;
    else if (!run_q)
      slow_q <= 1'b0;
    else
      slow_q <= use_xtal ? xt_sync_q[1] : rc_sync_q[1];
  end

  // pll control
  logic [17:0] pll_cnt_q;
  logic        pll_on;
  logic        fast_ok;
  logic        fast_q;
  logic [3:0]  div_q;
  logic        div_out_q;

  assign pll_on  = fast_en_q && !stop_any && !i_halt_fast_mode;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pll_cnt_q <= 18'h0;
    else if (!pll_on)
      pll_cnt_q <= 18'h0;
    else if (!fast_ok)
      pll_cnt_q <= pll_cnt_q + 18'h1;
  end

  assign fast_ok = pll_on && (pll_cnt_q >= (wake_sel_q ? PLL_EARLY_CYC : PLL_STABLE_CYCLES));

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      fast_q <= 1'b0;
    else
      fast_q <= fast_ok & pll_sync_q[1];
  end

  // divider counts pll edges; output is 1/2, 1/4, 1/8 or 1/16
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      div_q <= 4'h0;
    else if (!fast_ok)
      div_q <= 4'h0;
    else if (pll_rise)
      div_q <= div_q + 4'h1;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      div_out_q <= 1'b0;
    else
      div_out_q <= fast_out_q[BIT_DIV_OUT_EN] & div_q[fast_out_q[POS_DIV_SEL +: 2]];
  end

  // read port: data one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        ADDR_SLOW_SEL:  o_rdata <= {6'h00, slow_sel_q};
        ADDR_BACKUP:    o_rdata <= {6'h00, status_q, (sel_xtal && !use_xtal)};
        ADDR_FREQ_CTRL: o_rdata <= {6'h00, fast_ok, fast_en_q};
        ADDR_WAKE_TIME: o_rdata <= {7'h00, wake_sel_q};
        ADDR_FAST_OUT:  o_rdata <= {5'h00, fast_out_q};
        default:        o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end

  // crystal pins are kept out of port control while in use
  assign o_crystal_pin_port_config  = sel_xtal ? 2'h0 : i_crystal_pin_port_config;
  assign o_crystal_in_port_input_en = sel_xtal ? 1'b0 : i_crystal_in_port_input_en;
  assign o_crystal_osc_enable       = sel_xtal && (bk_q != BK_STOP) && !stop_any;
  assign o_slow_clock_out           = slow_q;
  assign o_slow_src_is_rc           = !use_xtal;
  assign o_cpu_run                  = run_q;
  assign o_clock_backup_irq         = irq_q;
  assign o_pll_enable               = pll_on;
  assign o_pll_multiplier           = opt_sync_q[1] ? PLL_MULT_24M : PLL_MULT_16M;
  assign o_fast_clock_out           = fast_q;
  assign o_divided_fast_clock_pin   = div_out_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  a_xtal_select_backup: assert property (
    sel_write && (i_wdata[1:0] == SEL_CRYSTAL) && !sel_xtal && bk_q == BK_RC |=> bk_q == BK_START)
    else $error("crystal select did not enter backup");
  a_rc_until_release: assert property (
    run_q && bk_q != BK_XTAL |=> o_slow_clock_out == $past(rc_sync_q[1]))
    else $error("crystal routed before release");
  a_release_routes: assert property (
    bk_q == BK_READY && release_write && !sel_write && !stop_any |=> use_xtal)
    else $error("release did not route crystal");
  a_stall_fails: assert property (
    bk_q == BK_XTAL && stall && !sel_write && !stop_any |=> bk_q == BK_FAIL && o_clock_backup_irq)
    else $error("stall did not switch to rc");
  a_stop_halts_xtal: assert property (
    stop_any |-> !o_crystal_osc_enable)
    else $error("crystal running in stop");
  a_pll_stops: assert property (
    (i_halt_fast_mode || stop_any) |-> !o_pll_enable ##1 !o_fast_clock_out)
    else $error("pll running in halt or stop");
  a_early_wake: assert property (
    $rose(pll_on) && wake_sel_q |-> !fast_ok [*8])
    else $error("fast clock supplied too early");
  a_port_ignored: assert property (
    sel_xtal |-> o_crystal_pin_port_config == 2'h0 && !o_crystal_in_port_input_en)
    else $error("port config not ignored");
  a_wake_count: assert property (
    $fell(stop_any) |-> !o_cpu_run [*3])
    else $error("cpu resumed before rc count");
  a_stab_irq: assert property (
    bk_q == BK_STAB && stab_done && !sel_write && !stop_any |=> o_clock_backup_irq && !status_q)
    else $error("no interrupt after stabilization");

  c_released: cover property (bk_q == BK_READY ##1 bk_q == BK_XTAL);
  c_failure: cover property (bk_q == BK_XTAL ##1 bk_q == BK_FAIL);
  c_fast_on: cover property ($rose(fast_ok));

endmodule // slow_clock_backup
`default_nettype wire

// ---- verif/crystal_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module crystal_source_model #(
  parameter int HALF_PERIOD_NS = 20
) (
  input  wire logic i_enable,
  input  wire logic i_stall,
  output logic      o_pin
);
  // a halted or stalled crystal stands low; it never keeps toggling on its own
  initial o_pin = 1'b0;

  always
  begin
    #(HALF_PERIOD_NS);
    if (i_enable && !i_stall)
      o_pin = ~o_pin;
    else
      o_pin = 1'b0;
  end
endmodule // crystal_source_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
  import clk_backup_pkg::*;
;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       oth_rst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       rc = 1'b0;
  logic       pll = 1'b0;
  logic       opt = 1'b0;
  logic       stop = 1'b0;
  logic       dstop = 1'b0;
  logic       halt = 1'b0;
  logic       stall = 1'b0;
  logic [7:0] rdata;
  logic       xtal_pin;
  logic [1:0] cfg_o;
  logic       ie_o;
  logic       osc_en;
  logic       src_rc;
  logic       cpu_run;
  logic       irq;
  logic       pll_en;
  logic [9:0] mult;
  logic       fast_clk;
  logic       div_pin;
  logic       slow_o;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  always #5 clk = ~clk;
  always #40 rc = ~rc;
  always #20 pll = ~pll;

  crystal_source_model xtal (.i_enable(osc_en), .i_stall(stall), .o_pin(xtal_pin));

  slow_clock_backup #(
    .XTAL_START_CYCLES(26'd20),
    .XTAL_STOP_CYCLES (20'd50),
    .PLL_STABLE_CYCLES(18'd40)
  ) dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_other_reset(oth_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rc_clk(rc), .i_crystal_input_pin(xtal_pin),
    .i_pll_clk(pll), .i_pll_24mhz_option(opt), .i_stop_mode(stop), .i_deep_stop_mode(dstop),
    .i_halt_fast_mode(halt), .i_crystal_pin_port_config(2'h3), .i_crystal_in_port_input_en(1'b1),
    .o_crystal_pin_port_config(cfg_o), .o_crystal_in_port_input_en(ie_o), .o_crystal_osc_enable(osc_en),
    .o_slow_clock_out(slow_o), .o_slow_src_is_rc(src_rc), .o_cpu_run(cpu_run), .o_clock_backup_irq(irq),
    .o_pll_enable(pll_en), .o_pll_multiplier(mult), .o_fast_clock_out(fast_clk),
    .o_divided_fast_clock_pin(div_pin)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // changes seen on the divided, fast and slow clock outputs over 64 cycles
  task automatic count_changes(output int nd, output int nf, output int ns);
    logic pd;
    logic pf;
    logic ps;
    nd = 0;
    nf = 0;
    ns = 0;
    pd = div_pin;
    pf = fast_clk;
    ps = slow_o;
    repeat (64)
    begin
      @(posedge clk);
      #1;
      if (div_pin !== pd)
        nd++;
      if (fast_clk !== pf)
        nf++;
      if (slow_o !== ps)
        ns++;
      pd = div_pin;
      pf = fast_clk;
      ps = slow_o;
    end
  endtask

  task automatic t_powerup();
    int k;
    int nd;
    int nf;
    int ns;
    repeat (500 * 8) @(posedge clk);
    #1;
    check(cpu_run, 1'b0);
    k = 0;
    while (cpu_run !== 1'b1 && k < 400)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check(cpu_run, 1'b1);
    count_changes(nd, nf, ns);
    check(ns >= 14 && ns <= 18, 1'b1);
    bus_rd(ADDR_SLOW_SEL, 8'h00);
    check({cfg_o, ie_o}, 3'h7);
  endtask

  task automatic t_crystal();
    int n;
    int nd;
    int nf;
    int ns;
    bus_wr(ADDR_SLOW_SEL, 8'h01);
    check(osc_en, 1'b1);
    check({cfg_o, ie_o}, 3'h0);
    check(src_rc, 1'b1);
    bus_rd(ADDR_BACKUP, 8'h03);
    bus_wr(ADDR_BACKUP, 8'h01);
    bus_wr(ADDR_BACKUP, 8'h00);
    check(src_rc, 1'b1);
    wait_irq(40000, n);
    check(irq, 1'b1);
    check(n > 32000, 1'b1);
    bus_rd(ADDR_BACKUP, 8'h01);
    bus_wr(ADDR_BACKUP, 8'h01);
    check(src_rc, 1'b0);
    bus_rd(ADDR_BACKUP, 8'h00);
    count_changes(nd, nf, ns);
    check(ns >= 30 && ns <= 34, 1'b1);
  endtask

  task automatic t_failure();
    int n;
    stall = 1'b1;
    wait_irq(400, n);
    check(irq, 1'b1);
    check(n < 200, 1'b1);
    check(src_rc, 1'b1);
    bus_rd(ADDR_BACKUP, 8'h03);
    stall = 1'b0;
    wait_irq(40000, n);
    check(irq, 1'b1);
    check(src_rc, 1'b1);
    bus_rd(ADDR_BACKUP, 8'h01);
    bus_wr(ADDR_BACKUP, 8'h01);
    check(src_rc, 1'b0);
  endtask

  task automatic t_other_reset();
    @(posedge clk);
    oth_rst <= 1'b1;
    @(posedge clk);
    oth_rst <= 1'b0;
    #1;
    bus_rd(ADDR_SLOW_SEL, 8'h01);
    check(osc_en, 1'b1);
    check(src_rc, 1'b0);
  endtask

  task automatic t_pll();
    int nd;
    int nf;
    int ns;
    check(mult, PLL_MULT_16M);
    @(posedge clk);
    opt <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(mult, PLL_MULT_24M);
    bus_wr(ADDR_FREQ_CTRL, 8'h01);
    check(pll_en, 1'b1);
    bus_rd(ADDR_FREQ_CTRL, 8'h01);
    repeat (60) @(posedge clk);
    bus_rd(ADDR_FREQ_CTRL, 8'h03);
    @(posedge clk);
    halt <= 1'b1;
    #1;
    check(pll_en, 1'b0);
    @(posedge clk);
    halt <= 1'b0;
    bus_wr(ADDR_WAKE_TIME, 8'h01);
    bus_wr(ADDR_FREQ_CTRL, 8'h00);
    bus_wr(ADDR_FREQ_CTRL, 8'h01);
    repeat (2800) @(posedge clk);
    bus_rd(ADDR_FREQ_CTRL, 8'h01);
    repeat (300) @(posedge clk);
    bus_rd(ADDR_FREQ_CTRL, 8'h03);
    bus_wr(ADDR_FAST_OUT, 8'h01);
    count_changes(nd, nf, ns);
    check(nf >= 30 && nf <= 34, 1'b1);
    check(nd >= 14 && nd <= 18, 1'b1);
    bus_wr(ADDR_FAST_OUT, 8'h03);
    count_changes(nd, nf, ns);
    check(nd >= 6 && nd <= 10, 1'b1);
  endtask

  task automatic t_stop();
    int k;
    @(posedge clk);
    // system clock is taken to be on the slow clock already
    dstop <= 1'b1;
    #1;
    check(osc_en, 1'b0);
    check(pll_en, 1'b0);
    repeat (20) @(posedge clk);
    dstop <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(cpu_run, 1'b0);
    k = 0;
    while (cpu_run !== 1'b1 && k < 200)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check(cpu_run, 1'b1);
    check(k > 60, 1'b1);
    check(osc_en, 1'b1);
    check(src_rc, 1'b1);
    bus_rd(ADDR_BACKUP, 8'h03);
    bus_wr(ADDR_SLOW_SEL, 8'h00);
    check(osc_en, 1'b0);
    check({cfg_o, ie_o}, 3'h7);
  endtask

  task automatic t_external();
    bus_wr(ADDR_SLOW_SEL, 8'h03);
    check({cfg_o, ie_o}, 3'h0);
    check(osc_en, 1'b1);
    bus_wr(ADDR_SLOW_SEL, 8'h02);
    bus_rd(ADDR_SLOW_SEL, 8'h03);
    bus_rd(8'h10, 8'h00);
    bus_wr(ADDR_SLOW_SEL, 8'h00);
    bus_rd(ADDR_SLOW_SEL, 8'h00);
    check(src_rc, 1'b1);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    check(src_rc, 1'b1);
    check(cpu_run, 1'b0);
    @(posedge clk);
    rstn <= 1'b1;
    t_powerup();
    t_crystal();
    t_failure();
    t_other_reset();
    t_pll();
    t_stop();
    t_external();
    test_done();
  end
endmodule // tb
`default_nettype wire
